// File: rtl/driver_status_word_pkg.sv
// constants for the driver status word block
package status_pkg;
	// ==========================================================
	// register map
	localparam logic [6:0]  STATUS_WORD_OFFSET = 7'h6F;
	localparam logic [31:0] STATUS_WORD_RESET  = 32'h0000_0000;
	// ==========================================================
	// field positions
	localparam int STANDSTILL_BIT   = 31;
	localparam int CS_ACTUAL_HI     = 20;
	localparam int CS_ACTUAL_LO     = 16;
	localparam int SHUTDOWN_BIT     = 9;
	localparam int PREWARN_BIT      = 8;
	localparam int OPEN_LOAD_B_BIT  = 7;
	localparam int OPEN_LOAD_A_BIT  = 6;
	localparam int LOWSIDE_B_BIT    = 5;
	localparam int LOWSIDE_A_BIT    = 4;
	localparam int GROUND_B_BIT     = 3;
	localparam int GROUND_A_BIT     = 2;
	localparam int OVERHEAT_BIT     = 1;
	localparam int PREWARN_FLAG_BIT = 0;
	// ==========================================================
	// timing
	localparam int unsigned STANDSTILL_CLOCKS = 32'h0010_0000;
	localparam int unsigned PWM_BITS          = 8;
	// chopper modes; short flags are banked by this value
	typedef enum logic {CHOP_SPREAD, CHOP_QUIET} chop_mode_e;
endpackage

// File: rtl/motor_driver_status_flags.sv
// driver status word: protection latches, bridge enable, PWM and read port
`timescale 1ns/1ps
module motor_driver_status_flags #(
	parameter int unsigned STANDSTILL_CLOCKS = status_pkg::STANDSTILL_CLOCKS,
	parameter int unsigned PWM_BITS          = status_pkg::PWM_BITS
) (
	input  wire logic                CORE_CLK,
	input  wire logic                RESET_N,
	input  wire logic                STEP,
	input  wire logic                EXTERNAL_ENABLE_LOW_N,
	input  wire logic                DRIVER_ENABLE,
	input  wire logic                CHOPPER_MODE,
	input  wire logic [4:0]          CS_ACTUAL_IN,
	input  wire logic [PWM_BITS-1:0] PWM_AMPL_A,
	input  wire logic [PWM_BITS-1:0] PWM_AMPL_B,
	input  wire logic                SHUTDOWN_TEMP_CMP,
	input  wire logic                PREWARN_TEMP_CMP,
	input  wire logic                OPEN_LOAD_A_DET,
	input  wire logic                OPEN_LOAD_B_DET,
	input  wire logic [1:0]          LOWSIDE_SHORT_DET,
	input  wire logic [1:0]          GROUND_SHORT_DET,
	input  wire logic [6:0]          REG_ADDR,
	input  wire logic                REG_RD,
	input  wire logic                REG_WR,
	output logic [31:0]              REG_RDATA,
	output logic                     REG_RVALID,
	output logic                     REG_WACK,
	output logic                     BRIDGE_ENABLE,
	output logic [1:0]               COIL_PWM
);
	localparam int NSYNC = 10;

	if (PWM_BITS < 2 || PWM_BITS > 16) begin : g_pwm_width_check
		$error("pwm width out of range");
	end

	// ==========================================================
	// reset release
	logic rst_meta_ff;
	logic rst_n;
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_ff <= 1'b0;
			rst_n       <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n       <= rst_meta_ff;
		end
	end

	// ==========================================================
	// pin synchronisers, two flops per pin
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] meta_ff;
	logic [NSYNC-1:0] sync_ff;
	assign pin_raw = {STEP, EXTERNAL_ENABLE_LOW_N, SHUTDOWN_TEMP_CMP, PREWARN_TEMP_CMP,
		OPEN_LOAD_B_DET, OPEN_LOAD_A_DET, LOWSIDE_SHORT_DET, GROUND_SHORT_DET};
	for (genvar i = 0; i < NSYNC; i++) begin : g_sync
		always_ff @(posedge CORE_CLK or negedge rst_n) begin
			if (!rst_n) begin
				meta_ff[i] <= 1'b0;
				sync_ff[i] <= 1'b0;
			end else begin
				meta_ff[i] <= pin_raw[i];
				sync_ff[i] <= meta_ff[i];
			end
		end
	end

	logic       step_s;
	logic       ext_off_s;
	logic       shutdown_s;
	logic       prewarn_s;
	logic       olb_s;
	logic       ola_s;
	logic [1:0] ls_s;
	logic [1:0] gs_s;
	assign {step_s, ext_off_s, shutdown_s, prewarn_s, olb_s, ola_s, ls_s, gs_s} = sync_ff;

	// ==========================================================
	// step edge and standstill
	logic step_prev_ff;
	logic step_pulse;
	logic standstill;
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			step_prev_ff <= 1'b0;
		end else begin
			step_prev_ff <= step_s;
		end
	end
	assign step_pulse = step_s & ~step_prev_ff;

	standstill_timer #(
		.LIMIT (STANDSTILL_CLOCKS)
	) u_standstill (
		.clk        (CORE_CLK),
		.rst_n      (rst_n),
		.step_pulse (step_pulse),
		.standstill (standstill)
	);

	// ==========================================================
	// protection latches and bridge enable
	// short flags: [mode][lsB, lsA, gB, gA]
	logic [1:0][3:0] short_ff;
	logic [1:0][3:0] nxt_short;
	logic            overheat_ff;
	logic            nxt_overheat;
	logic            bridge_ff;
	logic            nxt_bridge;
	logic            clr_shorts;
	logic [3:0]      short_det;

	assign clr_shorts = ~DRIVER_ENABLE | ext_off_s;
	assign short_det  = {ls_s, gs_s};

	// new detections win over a clear in the same cycle
	always_comb begin
		for (int m = 0; m < 2; m++) begin
			nxt_short[m] = short_ff[m] & ~{4{clr_shorts}};
		end
		nxt_short[CHOPPER_MODE] = nxt_short[CHOPPER_MODE] | short_det;
		nxt_overheat = shutdown_s | (overheat_ff & prewarn_s);
		// open load is informative only and never gates the bridge
		nxt_bridge = DRIVER_ENABLE & ~ext_off_s & ~shutdown_s & ~nxt_overheat
			& ~(|nxt_short[0]) & ~(|nxt_short[1]);
	end

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			short_ff  <= '0;
			overheat_ff <= 1'b0;
			bridge_ff <= 1'b0;
		end else begin
			short_ff  <= nxt_short;
			overheat_ff <= nxt_overheat;
			bridge_ff <= nxt_bridge;
		end
	end

	// ==========================================================
	// voltage mode PWM, quiet chopper only
	logic [PWM_BITS-1:0] pwm_cnt_ff;
	logic [PWM_BITS-1:0] nxt_pwm_cnt;
	logic [1:0]          pwm_ff;
	logic [1:0]          nxt_pwm;
	logic                quiet;
	assign quiet = (CHOPPER_MODE == status_pkg::CHOP_QUIET);

	// duty sets effective coil voltage; other chopper lives elsewhere
	always_comb begin
		nxt_pwm_cnt = pwm_cnt_ff + PWM_BITS'(1);
		nxt_pwm[0]  = bridge_ff & quiet & (pwm_cnt_ff < PWM_AMPL_A);
		nxt_pwm[1]  = bridge_ff & quiet & (pwm_cnt_ff < PWM_AMPL_B);
	end

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			pwm_cnt_ff <= '0;
			pwm_ff     <= 2'b00;
		end else begin
			pwm_cnt_ff <= nxt_pwm_cnt;
			pwm_ff     <= nxt_pwm;
		end
	end

	// ==========================================================
	// status word and read port
	logic [31:0] word;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic        rvalid_ff;
	logic        wack_ff;
	logic [3:0]  shorts_now;
	assign shorts_now = short_ff[CHOPPER_MODE];

	// unlisted bits stay zero
	always_comb begin
		word = status_pkg::STATUS_WORD_RESET;
		word[status_pkg::STANDSTILL_BIT] = standstill;
		word[status_pkg::CS_ACTUAL_HI:status_pkg::CS_ACTUAL_LO] = CS_ACTUAL_IN;
		word[status_pkg::SHUTDOWN_BIT]     = shutdown_s;
		word[status_pkg::PREWARN_BIT]      = prewarn_s;
		word[status_pkg::OPEN_LOAD_B_BIT]  = olb_s;
		word[status_pkg::OPEN_LOAD_A_BIT]  = ola_s;
		word[status_pkg::LOWSIDE_B_BIT]    = shorts_now[3];
		word[status_pkg::LOWSIDE_A_BIT]    = shorts_now[2];
		word[status_pkg::GROUND_B_BIT]     = shorts_now[1];
		word[status_pkg::GROUND_A_BIT]     = shorts_now[0];
		word[status_pkg::OVERHEAT_BIT]     = overheat_ff;
		word[status_pkg::PREWARN_FLAG_BIT] = prewarn_s;
		nxt_rdata = rdata_ff;
		if (REG_RD) begin
			nxt_rdata = (REG_ADDR == status_pkg::STATUS_WORD_OFFSET) ? word : '0;
		end
	end

	// writes without a read in the same cycle are acknowledged and dropped
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff  <= '0;
			rvalid_ff <= 1'b0;
			wack_ff   <= 1'b0;
		end else begin
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= REG_RD;
			wack_ff   <= REG_WR & ~REG_RD;
		end
	end

	assign REG_RDATA     = rdata_ff;
	assign REG_RVALID    = rvalid_ff;
	assign REG_WACK      = wack_ff;
	assign BRIDGE_ENABLE = bridge_ff;
	assign COIL_PWM      = pwm_ff;

	// ==========================================================
	// checks
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!rst_n);

	sequence s_status_read;
		REG_RD && REG_ADDR == status_pkg::STATUS_WORD_OFFSET;
	endsequence

	property p_cs_read;
		s_status_read |=> REG_RVALID && REG_RDATA[20:16] == $past(CS_ACTUAL_IN);
	endproperty
	a_cs_read: assert property (p_cs_read) else $error("current scale mismatch");

	property p_shutdown_off;
		shutdown_s |=> !BRIDGE_ENABLE && overheat_ff;
	endproperty
	a_shutdown_off: assert property (p_shutdown_off) else $error("bridge on in shutdown");

	property p_prewarn_read;
		s_status_read |=> REG_RDATA[8] == $past(prewarn_s) && REG_RDATA[0] == $past(prewarn_s);
	endproperty
	a_prewarn_read: assert property (p_prewarn_read) else $error("prewarn bit wrong");

	property p_open_load_read;
		s_status_read |=> REG_RDATA[7:6] == $past({olb_s, ola_s});
	endproperty
	a_open_load_read: assert property (p_open_load_read) else $error("open load bits wrong");

	sequence s_short_seen;
		(|short_det) ##1 !clr_shorts [*2];
	endsequence

	property p_short_latch;
		// the bank is the one selected when the short was seen
		s_short_seen |-> (|short_ff[$past(CHOPPER_MODE, 2)]) && !BRIDGE_ENABLE;
	endproperty
	a_short_latch: assert property (p_short_latch) else $error("short not latched");

	property p_bank_other;
		!clr_shorts |=> short_ff[!$past(CHOPPER_MODE)] == $past(short_ff[!CHOPPER_MODE]);
	endproperty
	a_bank_other: assert property (p_bank_other) else $error("other bank changed");

	property p_short_clear;
		clr_shorts && !(|short_det) |=> short_ff[0] == 4'h0 && short_ff[1] == 4'h0;
	endproperty
	a_short_clear: assert property (p_short_clear) else $error("short not cleared");

	property p_overheat_hold;
		overheat_ff && prewarn_s |=> overheat_ff && !BRIDGE_ENABLE;
	endproperty
	a_overheat_hold: assert property (p_overheat_hold) else $error("overtemp released early");

	property p_reserved_zero;
		REG_RVALID |-> REG_RDATA[30:21] == 10'h000 && REG_RDATA[15:10] == 6'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

	property p_pwm_quiet;
		!quiet |=> COIL_PWM == 2'b00;
	endproperty
	a_pwm_quiet: assert property (p_pwm_quiet) else $error("pwm outside quiet mode");
endmodule // motor_driver_status_flags

// File: rtl/standstill_timer.sv
// standstill timer: counts clocks since the last step pulse
`timescale 1ns/1ps
module standstill_timer #(
	parameter int unsigned LIMIT = status_pkg::STANDSTILL_CLOCKS
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic step_pulse,
	output logic      standstill
);
	localparam int CW = $clog2(LIMIT + 1);
	localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);

	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic          stst_ff;
	logic          nxt_stst;

	// a limit below two leaves no room between a step and the flag
	if (LIMIT < 2) begin : g_limit_check
		$error("standstill limit too small");
	end

	// saturate at the limit so the flag holds until the next step
	always_comb begin
		nxt_cnt = cnt_ff;
		if (step_pulse) begin
			nxt_cnt = '0;
		end else if (cnt_ff != LIMIT_C) begin
			nxt_cnt = cnt_ff + CW'(1);
		end
		nxt_stst = (nxt_cnt == LIMIT_C);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff  <= '0;
			stst_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			stst_ff <= nxt_stst;
		end
	end

	assign standstill = stst_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// checks
	property p_stst_at_limit;
		stst_ff |-> (cnt_ff == LIMIT_C);
	endproperty
	a_stst_at_limit: assert property (p_stst_at_limit) else $error("standstill early");

	property p_step_clears_stst;
		step_pulse |=> !stst_ff;
	endproperty
	a_step_clears_stst: assert property (p_step_clears_stst) else $error("step kept standstill");
endmodule // standstill_timer

// File: test/host_model.sv
// host controller model that drives the status register port
`timescale 1ns/1ps
module host_model (
	input  wire logic        clk,
	output logic [6:0]       addr,
	output logic             rd,
	output logic             wr,
	input  wire logic [31:0] rdata,
	input  wire logic        rvalid,
	input  wire logic        wack
);
	// ==========================================
	// idle: no strobe raised at time zero
	initial begin
		addr = 7'h00;
		rd = 1'b0;
		wr = 1'b0;
	end
	// one read strobe; the word is taken in the cycle that rvalid stands
	task automatic read(input logic [6:0] a, output logic [31:0] d);
		@(posedge clk);
		#1;
		addr = a;
		rd = 1'b1;
		@(posedge clk);
		#1;
		d = rvalid ? rdata : 32'hFFFF_FFFF;
		rd = 1'b0;
		addr = ~a; // stale address must not matter
	endtask
	// one write strobe; acknowledge expected a cycle later
	task automatic write(input logic [6:0] a, output logic ack);
		@(posedge clk);
		#1;
		addr = a;
		wr = 1'b1;
		@(posedge clk);
		#1;
		ack = wack;
		wr = 1'b0;
		addr = ~a;
	endtask
endmodule // host_model

// File: test/tb_top.sv
// self-checking bench for the driver status word
`timescale 1ns/1ps
module tb_top;
	logic        core_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        step = 1'b0;
	logic        ext_en_low_n = 1'b0;
	logic        drv_en = 1'b1;
	logic        chop = 1'b0;
	logic [4:0]  cs = 5'h15;
	logic [7:0]  ampl_a = 8'hFF;
	logic [7:0]  ampl_b = 8'h40;
	logic        hot = 1'b0;
	logic        warm = 1'b0;
	logic [1:0]  open_ld = 2'h0;
	logic [3:0]  shorts = 4'h0;
	logic [6:0]  addr;
	logic        rd;
	logic        wr;
	logic [31:0] rdata;
	logic        rvalid;
	logic        wack;
	logic        bridge;
	logic [1:0]  pwm;
	logic [31:0] d;
	logic        ack;
	int          bad_count = 0;
	int          checks = 0;
	// ==========================================
	// clock and the design with a short standstill count
	always #5 core_clk = ~core_clk;
	motor_driver_status_flags #(.STANDSTILL_CLOCKS(16)) dut_u (
		.CORE_CLK(core_clk), .RESET_N(reset_n), .STEP(step),
		.EXTERNAL_ENABLE_LOW_N(ext_en_low_n), .DRIVER_ENABLE(drv_en),
		.CHOPPER_MODE(chop), .CS_ACTUAL_IN(cs), .PWM_AMPL_A(ampl_a),
		.PWM_AMPL_B(ampl_b), .SHUTDOWN_TEMP_CMP(hot), .PREWARN_TEMP_CMP(warm),
		.OPEN_LOAD_A_DET(open_ld[0]), .OPEN_LOAD_B_DET(open_ld[1]),
		.LOWSIDE_SHORT_DET(shorts[3:2]), .GROUND_SHORT_DET(shorts[1:0]),
		.REG_ADDR(addr), .REG_RD(rd), .REG_WR(wr), .REG_RDATA(rdata),
		.REG_RVALID(rvalid), .REG_WACK(wack), .BRIDGE_ENABLE(bridge),
		.COIL_PWM(pwm));
	host_model host_u (.clk(core_clk), .addr(addr), .rd(rd), .wr(wr),
		.rdata(rdata), .rvalid(rvalid), .wack(wack));
	// ==========================================
	// helpers; inputs always change 1 ns after the edge
	task automatic tick(input int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rs(input logic [31:0] exp);
		host_u.read(7'h6F, d);
		chk(d, exp);
	endtask
	task automatic bg(input logic exp);
		chk({31'h0, bridge}, {31'h0, exp});
	endtask
	// a full 256-cycle window sees every counter value once
	task automatic pwm_cnt(input logic [31:0] ea, input logic [31:0] eb);
		logic [31:0] na;
		logic [31:0] nb;
		na = 32'h0;
		nb = 32'h0;
		for (int i = 0; i < 256; i++) begin
			na += pwm[0];
			nb += pwm[1];
			tick(1);
		end
		chk(na, ea);
		chk(nb, eb);
	endtask
	task automatic results;
		$display("checks=%0d mismatches=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==========================================
	// watchdog well beyond the fewer than a thousand cycles used
	initial begin
		#200000;
		bad_count++;
		results;
	end
	// ==========================================
	// test sequence
	initial begin
		tick(16);
		reset_n = 1'b1;
		tick(30);
		rs(32'h8015_0000);
		host_u.read(7'h6E, d);
		chk(d, 32'h0);
		host_u.write(7'h6F, ack);
		chk({31'h0, ack}, 32'h1);
		rs(32'h8015_0000);
		cs = 5'h0A;
		tick(3);
		rs(32'h800A_0000);
		cs = 5'h15;
		$display("register test done");
		step = 1'b1;
		tick(4);
		rs(32'h0015_0000);
		step = 1'b0;
		tick(6);
		rs(32'h0015_0000);
		tick(10);
		rs(32'h8015_0000);
		$display("standstill test done");
		warm = 1'b1;
		tick(4);
		rs(32'h8015_0101);
		bg(1'b1);
		hot = 1'b1;
		tick(4);
		rs(32'h8015_0303);
		bg(1'b0);
		hot = 1'b0;
		tick(4);
		rs(32'h8015_0103);
		bg(1'b0);
		warm = 1'b0;
		tick(4);
		rs(32'h8015_0000);
		bg(1'b1);
		$display("temperature test done");
		open_ld = 2'h1;
		tick(4);
		rs(32'h8015_0040);
		bg(1'b1);
		open_ld = 2'h2;
		tick(4);
		rs(32'h8015_0080);
		open_ld = 2'h0;
		$display("open load test done");
		// each short latches, then clears by software or by pin
		for (int i = 0; i < 4; i++) begin
			shorts = 4'h1 << i;
			tick(4);
			shorts = 4'h0;
			tick(2);
			rs(32'h8015_0000 | (32'h4 << i));
			bg(1'b0);
			if (i % 2 == 1)
				ext_en_low_n = 1'b1;
			else
				drv_en = 1'b0;
			tick(4);
			ext_en_low_n = 1'b0;
			drv_en = 1'b1;
			tick(4);
			rs(32'h8015_0000);
			bg(1'b1);
		end
		shorts = 4'h4;
		tick(4);
		shorts = 4'h0;
		// let the synced detector fall before the bank switches
		tick(2);
		chop = 1'b1;
		rs(32'h8015_0000);
		chop = 1'b0;
		tick(2);
		rs(32'h8015_0010);
		drv_en = 1'b0;
		tick(4);
		drv_en = 1'b1;
		$display("short test done");
		chop = 1'b1;
		tick(4);
		pwm_cnt(32'd255, 32'd64);
		chop = 1'b0;
		tick(4);
		pwm_cnt(32'd0, 32'd0);
		$display("pwm test done");
		results;
	end
endmodule // tb_top
